// *** hw/css_sync.sv ***
// Two-flop synchroniser for asynchronous pin inputs.
module css_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Data
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // css_sync

// *** hw/css_top.sv ***
// Converter startup sequencer: register slave, synthesizer, calibration and link control.
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
module css_top (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // AHB-Lite slave
   input wire logic hsel_in,
   input wire logic [7:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // Straps and pins
   input wire logic pll_strap_enable_in,
   input wire logic ref_clock_source_select_in,
   input wire logic sync_single_ended_in,
   input wire logic timestamp_diff_p_in,
   input wire logic timestamp_diff_n_in,
   input wire logic calibration_trigger_pin_in,
   // Outputs
   output logic calibration_status_pin_out,
   output logic sampling_clock_run_out,
   output logic link_cgs_out,
   output logic link_ilas_out,
   output logic link_data_out,
   output logic multiframe_tick_out,
   output logic serdes_ref_out_enable_out
);
   localparam int A_INIT = 40;
   localparam int A_TRIM = 100;
   localparam int A_LOCK = 20;

   logic [5:0] pins_s;
   logic pll_strap_q, ref_strap_q, cal_pin_prev_q, soft_prev_q;
   logic rd_pend_q, wr_pend_q, hready_q, soft_rst_q;
   logic [7:0] rd_addr_q, wr_addr_q, init_cnt_q, pll_cnt_q, cal_cnt_q;
   logic init_q, trim_done_q, lock_q, foreground_complete_flag_q, cal_pin_q;
   logic pll_hold_q, trim_auto_q;
   logic [7:0] bias_q, trim_val_q, setup_q, serdes_q;
   logic [15:0] div_q;
   logic link_en_q, sync_sel_q, cal_en_q, soft_trig_q, pin_trig_en_q, overrange_detect_enable_q, stat_sel_q;
   logic [4:0] mode_q, km1_q, mf_cnt_q;
   logic [1:0] ilas_cnt_q;
   logic mf_tick_q;
   logic [31:0] rdata_q;
   css_pkg::css_pll_state_t pll_st_q;
   css_pkg::css_cal_state_t cal_st_q;
   css_pkg::css_link_state_t link_st_q;
   logic accept, wr_word, sync_level, is8b, trig_rise;

   css_sync #(.W(6)) u_sync (
      .clk_in(clk_sys_in),
      .rst_in(rst_in),
      .async_in({calibration_trigger_pin_in, timestamp_diff_n_in, timestamp_diff_p_in,
                 sync_single_ended_in, ref_clock_source_select_in, pll_strap_enable_in}),
      .sync_out(pins_s)
   );

   // Bus slave: writes commit at the end of the data phase, reads take one wait state
   // so that a read right behind a write to the same register sees the new value.
   assign accept = hsel_in && htrans_in[1] && hready_in;
   assign wr_word = wr_pend_q;

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         hready_q <= 1'b1;
         wr_addr_q <= 8'h00;
         rd_addr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end else begin
         wr_pend_q <= accept && hwrite_in && (hsize_in == css_pkg::CSS_HSIZE_WORD);
         if (accept) begin
            wr_addr_q <= haddr_in;
            rd_addr_q <= haddr_in;
         end
         if (accept && !hwrite_in) begin
            rd_pend_q <= 1'b1;
            hready_q <= 1'b0;
         end else if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
            hready_q <= 1'b1;
            case (rd_addr_q)
               css_pkg::CSS_OFS_STATUS: rdata_q <= {23'h0, ref_strap_q, pll_strap_q, sync_level,
                  link_st_q[css_pkg::CSS_LNK_DATA_BIT], cal_st_q == css_pkg::CSS_CAL_RUN,
                  foreground_complete_flag_q, lock_q, trim_done_q, init_q};
               css_pkg::CSS_OFS_PLL: rdata_q <= {8'h00, trim_val_q, bias_q, 6'h00, trim_auto_q, pll_hold_q};
               css_pkg::CSS_OFS_DIV: rdata_q <= {16'h0000, div_q};
               css_pkg::CSS_OFS_LINK: rdata_q <= {7'h00, sync_sel_q, 3'h0, km1_q, 3'h0, mode_q, 7'h00, link_en_q};
               css_pkg::CSS_OFS_CAL: rdata_q <= {16'h0000, setup_q, 3'h0, stat_sel_q, overrange_detect_enable_q,
                  pin_trig_en_q, soft_trig_q, cal_en_q};
               css_pkg::CSS_OFS_SERDES: rdata_q <= {24'h000000, serdes_q};
               default: rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign hrdata_out = rdata_q;
   assign hreadyout_out = hready_q;
   assign hresp_out = 1'b0;

   // Configuration registers; a software reset returns them to their defaults.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         soft_rst_q <= 1'b0;
         pll_hold_q <= css_pkg::CSS_RST_PLL_HOLD;
         trim_auto_q <= 1'b0;
         bias_q <= css_pkg::CSS_RST_BIAS;
         trim_val_q <= css_pkg::CSS_RST_TRIM;
         div_q <= css_pkg::CSS_RST_DIV;
         link_en_q <= 1'b0;
         mode_q <= 5'h00;
         km1_q <= 5'h00;
         sync_sel_q <= 1'b0;
         {cal_en_q, soft_trig_q, pin_trig_en_q, overrange_detect_enable_q, stat_sel_q} <= 5'h00;
         setup_q <= css_pkg::CSS_RST_SETUP;
         serdes_q <= css_pkg::CSS_RST_SERDES;
      end else begin
         soft_rst_q <= wr_word && (wr_addr_q == css_pkg::CSS_OFS_CTRL) && hwdata_in[css_pkg::CSS_CTRL_SOFT_RST];
         if (soft_rst_q) begin
            pll_hold_q <= css_pkg::CSS_RST_PLL_HOLD;
            trim_auto_q <= 1'b0;
            bias_q <= css_pkg::CSS_RST_BIAS;
            trim_val_q <= css_pkg::CSS_RST_TRIM;
            div_q <= css_pkg::CSS_RST_DIV;
            link_en_q <= 1'b0;
            mode_q <= 5'h00;
            km1_q <= 5'h00;
            sync_sel_q <= 1'b0;
            {cal_en_q, soft_trig_q, pin_trig_en_q, overrange_detect_enable_q, stat_sel_q} <= 5'h00;
            setup_q <= css_pkg::CSS_RST_SETUP;
            serdes_q <= css_pkg::CSS_RST_SERDES;
         end else if (wr_word) begin
            case (wr_addr_q)
               css_pkg::CSS_OFS_PLL: begin
                  pll_hold_q <= hwdata_in[css_pkg::CSS_PLL_HOLD];
                  trim_auto_q <= hwdata_in[css_pkg::CSS_PLL_AUTO];
                  bias_q <= hwdata_in[css_pkg::CSS_PLL_BIAS_LSB +: 8];
                  trim_val_q <= hwdata_in[css_pkg::CSS_PLL_TRIM_LSB +: 8];
               end
               css_pkg::CSS_OFS_DIV: div_q <= hwdata_in[15:0];
               css_pkg::CSS_OFS_LINK: begin
                  link_en_q <= hwdata_in[css_pkg::CSS_LINK_EN];
                  mode_q <= hwdata_in[css_pkg::CSS_LINK_MODE_LSB +: 5];
                  km1_q <= hwdata_in[css_pkg::CSS_LINK_KM1_LSB +: 5];
                  sync_sel_q <= hwdata_in[css_pkg::CSS_LINK_SYNC_SEL];
               end
               css_pkg::CSS_OFS_CAL: begin
                  cal_en_q <= hwdata_in[css_pkg::CSS_CAL_EN];
                  soft_trig_q <= hwdata_in[css_pkg::CSS_CAL_SOFT];
                  pin_trig_en_q <= hwdata_in[css_pkg::CSS_CAL_PIN_EN];
                  overrange_detect_enable_q <= hwdata_in[css_pkg::CSS_CAL_OVR];
                  stat_sel_q <= hwdata_in[css_pkg::CSS_CAL_STAT_SEL];
                  setup_q <= hwdata_in[css_pkg::CSS_CAL_SETUP_LSB +: 8];
               end
               css_pkg::CSS_OFS_SERDES: serdes_q <= hwdata_in[7:0];
               default: ;
            endcase
         end
      end
   end

   // Initialization timer; straps are caught while it runs, after the synchroniser has settled.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         init_cnt_q <= 8'h00;
         init_q <= 1'b0;
         pll_strap_q <= 1'b0;
         ref_strap_q <= 1'b0;
      end else if (soft_rst_q) begin
         init_cnt_q <= 8'h00;
         init_q <= 1'b0;
      end else if (!init_q) begin
         pll_strap_q <= pins_s[0];
         ref_strap_q <= pins_s[1];
         init_cnt_q <= init_cnt_q + 8'h01;
         if (init_cnt_q == css_pkg::CSS_INIT_CYC - 8'h01) begin
            init_q <= 1'b1;
         end
      end
   end

   // Synthesizer: held while the hold bit is set or the strap disables it.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pll_st_q <= css_pkg::CSS_PLL_HOLD_ST;
         pll_cnt_q <= 8'h00;
         trim_done_q <= 1'b0;
         lock_q <= 1'b0;
      end else if (pll_hold_q || !pll_strap_q || !init_q) begin
         pll_st_q <= css_pkg::CSS_PLL_HOLD_ST;
         pll_cnt_q <= 8'h00;
         trim_done_q <= 1'b0;
         lock_q <= 1'b0;
      end else begin
         pll_cnt_q <= pll_cnt_q + 8'h01;
         case (pll_st_q)
            css_pkg::CSS_PLL_HOLD_ST: begin
               pll_cnt_q <= 8'h00;
               pll_st_q <= trim_auto_q ? css_pkg::CSS_PLL_TRIM_ST : css_pkg::CSS_PLL_LOCKING_ST;
               trim_done_q <= !trim_auto_q;
            end
            css_pkg::CSS_PLL_TRIM_ST: if (pll_cnt_q == css_pkg::CSS_TRIM_CYC - 8'h01) begin
               pll_cnt_q <= 8'h00;
               pll_st_q <= css_pkg::CSS_PLL_LOCKING_ST;
               trim_done_q <= 1'b1;
            end
            css_pkg::CSS_PLL_LOCKING_ST: if (pll_cnt_q == css_pkg::CSS_LOCK_CYC - 8'h01) begin
               pll_st_q <= css_pkg::CSS_PLL_LOCKED_ST;
               lock_q <= 1'b1;
            end
            css_pkg::CSS_PLL_LOCKED_ST: pll_cnt_q <= 8'h00;
            default: pll_st_q <= css_pkg::CSS_PLL_HOLD_ST;
         endcase
      end
   end
   assign sampling_clock_run_out = !pll_st_q[0];

   // Foreground calibration; triggers only count while the engine runs in foreground mode.
   assign trig_rise = (soft_trig_q && !soft_prev_q) || (pin_trig_en_q && pins_s[5] && !cal_pin_prev_q);
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         soft_prev_q <= 1'b0;
         cal_pin_prev_q <= 1'b0;
         cal_st_q <= css_pkg::CSS_CAL_IDLE;
         cal_cnt_q <= 8'h00;
         foreground_complete_flag_q <= 1'b0;
      end else begin
         soft_prev_q <= soft_trig_q;
         cal_pin_prev_q <= pins_s[5];
         if (cal_en_q) begin
            case (cal_st_q)
               css_pkg::CSS_CAL_RUN: begin
                  cal_cnt_q <= cal_cnt_q + 8'h01;
                  if (cal_cnt_q == css_pkg::CSS_CAL_CYC - 8'h01) begin
                     cal_st_q <= css_pkg::CSS_CAL_DONE;
                     foreground_complete_flag_q <= 1'b1;
                  end
               end
               css_pkg::CSS_CAL_IDLE, css_pkg::CSS_CAL_DONE: if (trig_rise && !setup_q[css_pkg::CSS_SETUP_BG]) begin
                  cal_st_q <= css_pkg::CSS_CAL_RUN;
                  cal_cnt_q <= 8'h00;
                  foreground_complete_flag_q <= 1'b0;
               end
               default: cal_st_q <= css_pkg::CSS_CAL_IDLE;
            endcase
         end
      end
   end

   // The status pin follows the complete flag one cycle later unless it is deselected.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         cal_pin_q <= 1'b0;
         serdes_ref_out_enable_out <= 1'b0;
      end else begin
         cal_pin_q <= foreground_complete_flag_q && !stat_sel_q;
         serdes_ref_out_enable_out <= serdes_q[css_pkg::CSS_SERDES_EN];
      end
   end
   assign calibration_status_pin_out = cal_pin_q;

   // Link: sync is active low, a request restarts code group sync.
   assign sync_level = sync_sel_q ? (pins_s[3] && !pins_s[4]) : pins_s[2];
   assign is8b = css_pkg::css_is_8b10b(mode_q);

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         mf_cnt_q <= 5'h00;
         mf_tick_q <= 1'b0;
      end else if (!link_en_q || !is8b) begin
         mf_cnt_q <= 5'h00;
         mf_tick_q <= 1'b0;
      end else begin
         mf_tick_q <= mf_cnt_q == km1_q;
         mf_cnt_q <= (mf_cnt_q == km1_q) ? 5'h00 : mf_cnt_q + 5'h01;
      end
   end
   assign multiframe_tick_out = mf_tick_q;

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         link_st_q <= css_pkg::CSS_LNK_OFF;
         ilas_cnt_q <= 2'h0;
      end else if (!link_en_q) begin
         link_st_q <= css_pkg::CSS_LNK_OFF;
         ilas_cnt_q <= 2'h0;
      end else if (!is8b) begin
         link_st_q <= css_pkg::CSS_LNK_DATA;
      end else begin
         case (link_st_q)
            css_pkg::CSS_LNK_CGS: if (sync_level) begin
               link_st_q <= css_pkg::CSS_LNK_ILAS;
               ilas_cnt_q <= 2'h0;
            end
            css_pkg::CSS_LNK_ILAS: if (!sync_level) begin
               link_st_q <= css_pkg::CSS_LNK_CGS;
            end else if (mf_tick_q) begin
               ilas_cnt_q <= ilas_cnt_q + 2'h1;
               if (ilas_cnt_q == css_pkg::CSS_ILAS_LAST_MF) begin
                  link_st_q <= css_pkg::CSS_LNK_DATA;
               end
            end
            css_pkg::CSS_LNK_DATA: if (!sync_level) begin
               link_st_q <= css_pkg::CSS_LNK_CGS;
            end
            default: link_st_q <= css_pkg::CSS_LNK_CGS;
         endcase
      end
   end
   assign link_cgs_out = link_st_q[css_pkg::CSS_LNK_CGS_BIT];
   assign link_ilas_out = link_st_q[css_pkg::CSS_LNK_ILAS_BIT];
   assign link_data_out = link_st_q[css_pkg::CSS_LNK_DATA_BIT];

   a_init_after_reset: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      soft_rst_q |=> !init_q ##A_INIT init_q) else $error("init flag timing wrong");
   a_trim_then_lock: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      pll_st_q == css_pkg::CSS_PLL_HOLD_ST && !pll_hold_q && pll_strap_q && init_q && trim_auto_q
      |=> pll_st_q == css_pkg::CSS_PLL_TRIM_ST ##A_TRIM trim_done_q ##A_LOCK lock_q)
      else $error("trim or lock timing wrong");
   a_hold_clears_flags: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      pll_hold_q |=> !lock_q && !trim_done_q && !sampling_clock_run_out) else $error("hold left flags set");
   a_link_halted: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !link_en_q |=> link_st_q == css_pkg::CSS_LNK_OFF && !link_data_out) else $error("link not halted");
   a_cal_frozen: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !cal_en_q |=> $stable(cal_cnt_q) && $stable(cal_st_q)) else $error("calibration ran while halted");
   a_cal_start: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      cal_en_q && trig_rise && !setup_q[css_pkg::CSS_SETUP_BG] && cal_st_q != css_pkg::CSS_CAL_RUN
      |=> cal_st_q == css_pkg::CSS_CAL_RUN && !foreground_complete_flag_q) else $error("trigger did not start calibration");
   a_cal_finish: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      cal_en_q && cal_st_q == css_pkg::CSS_CAL_RUN && cal_cnt_q == css_pkg::CSS_CAL_CYC - 8'h01 && !stat_sel_q
      ##1 !stat_sel_q |=> foreground_complete_flag_q && calibration_status_pin_out) else $error("finish not reported");
   a_sync_request: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      link_en_q && is8b && link_data_out && !sync_level |=> link_cgs_out || !link_en_q || !is8b)
      else $error("sync request ignored");
   a_sync_ignored: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      link_en_q && !is8b ##1 link_en_q && !is8b |-> link_data_out) else $error("64B/66B link not in data");
   a_mf_tick_8b: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !is8b |=> !multiframe_tick_out) else $error("multiframe tick outside 8B/10B");
   a_read_wait: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      accept && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out) else $error("read wait state wrong");
endmodule // css_top

// *** inc/css_pkg.sv ***
// Constants, types and helpers of the converter startup sequencer.
// Behaviour
// - Software reset, then initialization flag reads one.
// - Hold release starts trim and synthesizer.
// - Link engine disable halts link machine.
// - Calibration engine disable halts calibration.
// - Multiframe length used only in 8B/10B.
// - Sync source select picks sync input.
// - Device reports trim completion and lock.
// - Rising trigger edge starts foreground calibration.
// - Finish raises status pin and complete flag.
// - 8B/10B obeys sync; 64B/66B ignores it.
package css_pkg;
   localparam int CSS_CLK_PERIOD_NS = 50;
   // Internal durations; the synthesizer and calibration are modelled by counters.
   localparam int CSS_INIT_TIME_NS = 2000;
   localparam int CSS_TRIM_TIME_NS = 5000;
   localparam int CSS_LOCK_TIME_NS = 1000;
   localparam int CSS_CAL_TIME_NS = 10000;
   localparam logic [7:0] CSS_INIT_CYC = 8'((CSS_INIT_TIME_NS + CSS_CLK_PERIOD_NS - 1) / CSS_CLK_PERIOD_NS);
   localparam logic [7:0] CSS_TRIM_CYC = 8'((CSS_TRIM_TIME_NS + CSS_CLK_PERIOD_NS - 1) / CSS_CLK_PERIOD_NS);
   localparam logic [7:0] CSS_LOCK_CYC = 8'((CSS_LOCK_TIME_NS + CSS_CLK_PERIOD_NS - 1) / CSS_CLK_PERIOD_NS);
   localparam logic [7:0] CSS_CAL_CYC = 8'((CSS_CAL_TIME_NS + CSS_CLK_PERIOD_NS - 1) / CSS_CLK_PERIOD_NS);
   // Register byte offsets.
   localparam logic [7:0] CSS_OFS_CTRL = 8'h00;
   localparam logic [7:0] CSS_OFS_STATUS = 8'h04;
   localparam logic [7:0] CSS_OFS_PLL = 8'h08;
   localparam logic [7:0] CSS_OFS_DIV = 8'h0c;
   localparam logic [7:0] CSS_OFS_LINK = 8'h10;
   localparam logic [7:0] CSS_OFS_CAL = 8'h14;
   localparam logic [7:0] CSS_OFS_SERDES = 8'h18;
   // Field positions.
   localparam int CSS_CTRL_SOFT_RST = 0;
   localparam int CSS_PLL_HOLD = 0;
   localparam int CSS_PLL_AUTO = 1;
   localparam int CSS_PLL_BIAS_LSB = 8;
   localparam int CSS_PLL_TRIM_LSB = 16;
   localparam int CSS_DIV_P_LSB = 0;
   localparam int CSS_DIV_V_LSB = 4;
   localparam int CSS_DIV_N_LSB = 8;
   localparam int CSS_LINK_EN = 0;
   localparam int CSS_LINK_MODE_LSB = 8;
   localparam int CSS_LINK_KM1_LSB = 16;
   localparam int CSS_LINK_SYNC_SEL = 24;
   localparam int CSS_CAL_EN = 0;
   localparam int CSS_CAL_SOFT = 1;
   localparam int CSS_CAL_PIN_EN = 2;
   localparam int CSS_CAL_OVR = 3;
   localparam int CSS_CAL_STAT_SEL = 4;
   localparam int CSS_CAL_SETUP_LSB = 8;
   localparam int CSS_SETUP_BG = 0;
   // Reset values.
   localparam logic CSS_RST_PLL_HOLD = 1'b1;
   localparam logic [7:0] CSS_RST_BIAS = 8'h00;
   localparam logic [7:0] CSS_RST_TRIM = 8'h00;
   localparam logic [15:0] CSS_RST_DIV = 16'h0000;
   localparam logic [7:0] CSS_RST_SETUP = 8'h00;
   localparam logic [7:0] CSS_RST_SERDES = 8'h00;
   localparam int CSS_SERDES_EN = 7;
   // Link formats at or above this code use 64B/66B.
   localparam logic [4:0] CSS_FIRST_66B_MODE = 5'h08;
   localparam logic [1:0] CSS_ILAS_LAST_MF = 2'h3;
   localparam logic [2:0] CSS_HSIZE_WORD = 3'h2;
   localparam int CSS_LNK_CGS_BIT = 1;
   localparam int CSS_LNK_ILAS_BIT = 2;
   localparam int CSS_LNK_DATA_BIT = 3;

   typedef enum logic [3:0] {
      CSS_PLL_HOLD_ST = 4'h1,
      CSS_PLL_TRIM_ST = 4'h2,
      CSS_PLL_LOCKING_ST = 4'h4,
      CSS_PLL_LOCKED_ST = 4'h8
   } css_pll_state_t;
   typedef enum logic [2:0] {
      CSS_CAL_IDLE = 3'h1,
      CSS_CAL_RUN = 3'h2,
      CSS_CAL_DONE = 3'h4
   } css_cal_state_t;
   typedef enum logic [3:0] {
      CSS_LNK_OFF = 4'h1,
      CSS_LNK_CGS = 4'h2,
      CSS_LNK_ILAS = 4'h4,
      CSS_LNK_DATA = 4'h8
   } css_link_state_t;

   function automatic logic css_is_8b10b(input logic [4:0] mode);
      return mode < CSS_FIRST_66B_MODE;
   endfunction
endpackage

// *** tb/css_rx_model.sv ***
// Receiver-side model: drives SYNC on the input chosen by diff_sel_in and judges data validity.
module css_rx_model (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Control and status
   input wire logic ready_in,
   input wire logic link_data_in,
   input wire logic cal_stat_in,
   input wire logic diff_sel_in,
   // Sync lines and verdict
   output logic sync_se_out,
   output logic ts_p_out,
   output logic ts_n_out,
   output logic valid_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic sync_q;
   // SYNC stays low, a resync request, until the receiver is ready.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync_q <= 1'b0;
      end else begin
         sync_q <= ready_in;
      end
   end
   // Only the chosen input carries SYNC, so a wrong source choice keeps the link in code group sync.
   assign sync_se_out = sync_q & ~diff_sel_in;
   assign ts_p_out = sync_q & diff_sel_in;
   assign ts_n_out = ~ts_p_out;
   assign valid_out = link_data_in & cal_stat_in;
endmodule // css_rx_model

// *** tb/tb.sv ***
// Self-checking bench of the startup sequencer.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0, rx_rdy = 1'b0, trig = 1'b0, ref_sel = 1'b0, rd_ph = 1'b0, pll_en = 1'b1;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, rdat = 32'h0, div_v, mon_e, mon_m, hrdata;
   logic [31:0] seed = 32'h00006cf7;
   logic hready, hresp, stat_pin, run, cgs, ilas, dat, tick, sref, sync_se, ts_p, ts_n, valid;
   logic [31:0] exp_q[$], msk_q[$];
   int n_mismatch = 0, cmp_count = 0, n;
   always #25 clk_sys_in = ~clk_sys_in;
   css_top css_top_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
      .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .pll_strap_enable_in(pll_en),
      .ref_clock_source_select_in(ref_sel), .sync_single_ended_in(sync_se), .timestamp_diff_p_in(ts_p),
      .timestamp_diff_n_in(ts_n), .calibration_trigger_pin_in(trig), .calibration_status_pin_out(stat_pin),
      .sampling_clock_run_out(run), .link_cgs_out(cgs), .link_ilas_out(ilas), .link_data_out(dat),
      .multiframe_tick_out(tick), .serdes_ref_out_enable_out(sref));
   css_rx_model css_rx_model_i (.clk_in(clk_sys_in), .rst_in(rst_in), .ready_in(rx_rdy), .link_data_in(dat),
      .cal_stat_in(stat_pin), .diff_sel_in(1'b1), .sync_se_out(sync_se), .ts_p_out(ts_p), .ts_n_out(ts_n),
      .valid_out(valid));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // One single transfer; a read notes its expected word and mask for the monitor.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, e, m);
      @(posedge clk_sys_in);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk_sys_in); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rd_ph <= ~w;
      exp_q.push_back(e);
      msk_q.push_back(w ? 32'h0 : m);
      do @(posedge clk_sys_in); while (hready !== 1'b1);
      rdat = hrdata;
      rd_ph <= 1'b0;
   endtask
   task automatic poll(input int b);
      int k;
      k = 0;
      rdat = 32'h0;
      while (rdat[b] !== 1'b1 && k < 200) begin
         xfer(1'b0, 8'h04, 32'h0, 32'h0, 32'h0);
         k++;
      end
      chk("poll limit", 32'(rdat[b] === 1'b1), 32'h1);
   endtask
   task automatic wait_pin();
      n = 0;
      while (stat_pin !== 1'b1) begin
         @(posedge clk_sys_in);
         n++;
      end
   endtask
   always @(posedge clk_sys_in) begin
      if (hwrite === 1'b0 && rd_ph === 1'b1 && hready === 1'b1 || hwrite === 1'b1 && exp_q.size() > 0) begin
         mon_e = exp_q.pop_front();
         mon_m = msk_q.pop_front();
         chk("hresp", 32'(hresp), 32'h0);
         if (mon_m != 32'h0) chk("hrdata", hrdata & mon_m, mon_e & mon_m);
      end
   end
   initial begin
      #250000;
      n_mismatch++;
      complete_run();
   end
   initial begin
      div_v = rnd() & 32'h0000ffff;
      ref_sel <= div_v[3];
      repeat (6) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      xfer(1'b0, 8'h04, 32'h0, 32'h0, 32'h1);
      poll(0);
      xfer(1'b0, 8'h04, 32'h0, {23'h0, ref_sel, 1'b1, 7'h00}, 32'h180);
      xfer(1'b0, 8'h08, 32'h0, 32'h1, 32'hffffff);
      xfer(1'b1, 8'h08, 32'h4a01, 32'h0, 32'h0);
      xfer(1'b1, 8'h0c, div_v, 32'h0, 32'h0);
      xfer(1'b0, 8'h0c, 32'h0, div_v, 32'hffff);
      xfer(1'b1, 8'h00, 32'h1, 32'h0, 32'h0);
      xfer(1'b0, 8'h04, 32'h0, 32'h0, 32'h1);
      xfer(1'b0, 8'h08, 32'h0, 32'h1, 32'hffffff);
      poll(0);
      xfer(1'b1, 8'h08, 32'h4a01, 32'h0, 32'h0);
      xfer(1'b1, 8'h0c, div_v, 32'h0, 32'h0);
      xfer(1'b1, 8'h08, 32'h4a03, 32'h0, 32'h0);
      xfer(1'b1, 8'h08, 32'h4a02, 32'h0, 32'h0);
      xfer(1'b0, 8'h04, 32'h0, 32'h0, 32'h6);
      chk("clock run", run, 32'h1);
      poll(1);
      xfer(1'b0, 8'h04, 32'h0, 32'h2, 32'h6);
      poll(2);
      xfer(1'b1, 8'h08, 32'h4a01, 32'h0, 32'h0);
      xfer(1'b1, 8'h08, {8'h00, div_v[15:8], 16'h4a00}, 32'h0, 32'h0);
      xfer(1'b0, 8'h04, 32'h0, 32'h2, 32'h6);
      xfer(1'b0, 8'h08, 32'h0, {8'h00, div_v[15:8], 16'h4a00}, 32'hffffff);
      poll(2);
      xfer(1'b1, 8'h18, 32'h80, 32'h0, 32'h0);
      xfer(1'b1, 8'h14, 32'h200, 32'h0, 32'h0);
      xfer(1'b0, 8'h14, 32'h0, 32'h200, 32'hff1f);
      xfer(1'b1, 8'h14, 32'h1, 32'h0, 32'h0);
      xfer(1'b1, 8'h10, 32'h01030001, 32'h0, 32'h0);
      chk("serdes ref", sref, 32'h1);
      repeat (4) @(posedge clk_sys_in);
      chk("cgs wait", cgs, 32'h1);
      n = 0;
      repeat (16) begin
         @(posedge clk_sys_in);
         if (tick === 1'b1) n++;
      end
      chk("mf ticks", 32'(n), 32'h4);
      rx_rdy <= 1'b1;
      n = 0;
      while (dat !== 1'b1) begin
         @(posedge clk_sys_in);
         n++;
      end
      chk("ilas span", 32'(n >= 13 && n <= 24), 32'h1);
      xfer(1'b0, 8'h04, 32'h0, 32'h60, 32'h60);
      rx_rdy <= 1'b0;
      repeat (6) @(posedge clk_sys_in);
      chk("resync", cgs, 32'h1);
      xfer(1'b1, 8'h10, 32'h01030801, 32'h0, 32'h0);
      repeat (3) @(posedge clk_sys_in);
      chk("66b data", dat, 32'h1);
      chk("66b tick", tick, 32'h0);
      xfer(1'b1, 8'h14, 32'h3, 32'h0, 32'h0);
      xfer(1'b0, 8'h04, 32'h0, 32'h10, 32'h18);
      wait_pin();
      chk("cal span", 32'(n >= 190 && n <= 202), 32'h1);
      xfer(1'b0, 8'h04, 32'h0, 32'h8, 32'h18);
      chk("valid", valid, 32'h1);
      xfer(1'b1, 8'h14, 32'h5, 32'h0, 32'h0);
      trig <= 1'b1;
      repeat (6) @(posedge clk_sys_in);
      xfer(1'b0, 8'h04, 32'h0, 32'h10, 32'h18);
      xfer(1'b1, 8'h14, 32'h4, 32'h0, 32'h0);
      repeat (250) @(posedge clk_sys_in);
      chk("cal halted", stat_pin, 32'h0);
      xfer(1'b1, 8'h14, 32'h5, 32'h0, 32'h0);
      wait_pin();
      chk("cal resumed", 32'(n <= 202), 32'h1);
      xfer(1'b1, 8'h10, 32'h0, 32'h0, 32'h0);
      repeat (2) @(posedge clk_sys_in);
      chk("link halted", {cgs, ilas, dat}, 32'h0);
      ref_sel <= 1'b0;
      pll_en <= 1'b0;
      xfer(1'b1, 8'h00, 32'h1, 32'h0, 32'h0);
      poll(0);
      xfer(1'b0, 8'h04, 32'h0, 32'h0, 32'h186);
      xfer(1'b0, 8'h40, 32'h0, 32'h0, 32'hffffffff);
      complete_run();
   end
endmodule // tb
